// ### xmr_regs.svh
// bit positions, codes and timing counts for extended register writes
`ifndef XMR_REGS_SVH
`define XMR_REGS_SVH

// ----------------------------------------------------------------------
// extended register one fields
// ----------------------------------------------------------------------
`define XMR_ONE_DLL_OFF_BIT 0
`define XMR_ONE_HALF_DRV_BIT 1
`define XMR_ONE_ODT_LO_BIT 2
`define XMR_ONE_PCD_LSB 3
`define XMR_ONE_ODT_HI_BIT 6
`define XMR_ONE_CAL_LSB 7
`define XMR_ONE_NDQS_OFF_BIT 10

// ----------------------------------------------------------------------
// extended register two fields and legal mask
// ----------------------------------------------------------------------
`define XMR_TWO_PARTIAL_ARRAY_SELF_REFRESH_LSB 0
`define XMR_TWO_DCC_BIT 3
`define XMR_TWO_HTSR_BIT 7
`define XMR_TWO_INIT_MASK 13'h0087

// ----------------------------------------------------------------------
// bank selects and calibration codes
// ----------------------------------------------------------------------
`define XMR_BANK_ONE 2'h1
`define XMR_BANK_TWO 2'h2
`define XMR_BANK_THREE 2'h3
`define XMR_CAL_EXIT 3'h0
`define XMR_CAL_DRIVE1 3'h1
`define XMR_CAL_DRIVE0 3'h2
`define XMR_CAL_ADJUST 3'h4
`define XMR_CAL_DEFAULT 3'h7

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define XMR_CLK_NS 10
`define XMR_MRD_CYC 2
`define XMR_DLL_LOCK_CYC 200

`endif

// ### xmr_pkg.sv
// types shared by the extended register write controller
package xmr_pkg;
    typedef enum logic [2:0]
    {
        XMR_IDLE = 3'b000,
        XMR_ISSUE = 3'b001,
        XMR_RECOVER = 3'b010,
        XMR_EXIT = 3'b011,
        XMR_EXIT_RECOVER = 3'b100
    } xmr_state_type;

    typedef enum logic [1:0]
    {
        XMR_SEL_ONE = 2'b01,
        XMR_SEL_TWO = 2'b10,
        XMR_SEL_THREE = 2'b11
    } xmr_sel_type;
endpackage

// ### xmr_wait.sv
// down counter that holds busy for a loaded number of cycles
module xmr_wait #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic busy
);
    logic [WIDTH-1:0] left_ff;

    // load a count and decrement to zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            left_ff <= '0;
        else if (load)
            left_ff <= count;
        else if (left_ff != '0)
            left_ff <= left_ff - 1'b1;
    end

    assign busy = (left_ff != '0);
endmodule

// ### xmr_ctrl.sv
// controller that issues extended register writes to a ddr2 device
`include "xmr_regs.svh"
module xmr_ctrl #(
    parameter int MRD_CYC = `XMR_MRD_CYC,
    parameter int LOCK_CYC = `XMR_DLL_LOCK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    // user side
    input wire logic req_valid,
    input wire xmr_pkg::xmr_sel_type req_sel,
    input wire logic [12:0] req_data,
    input wire logic banks_precharged,
    input wire logic dll_reset_done,
    output logic req_ready,
    output logic wr_done,
    output logic cal_active,
    output logic read_allowed,
    output logic [12:0] shadow_one,
    output logic [12:0] shadow_two,
    output logic [2:0] written,
    // device pins
    output logic mem_cke,
    output logic mem_cs_n,
    output logic mem_ras_n,
    output logic mem_cas_n,
    output logic mem_we_n,
    output logic [1:0] mem_ba,
    output logic [12:0] mem_addr
);
    xmr_pkg::xmr_state_type state_ff, nxt_state;
    logic [12:0] word_ff;
    logic [1:0] bank_ff;
    logic cmd_ff;
    logic mrd_busy;
    logic lock_busy;
    logic dll_on_ff;
    logic needs_exit;
    logic [12:0] clean_data;
    logic [12:0] exit_word;

    // ------------------------------------------------------------------
    // request shaping
    // ------------------------------------------------------------------
    // force legal bits per register and handle calibration field
    always_comb
    begin
        clean_data = req_data;
        unique case (req_sel)
            xmr_pkg::XMR_SEL_TWO:
                clean_data = req_data & `XMR_TWO_INIT_MASK;
            xmr_pkg::XMR_SEL_THREE:
                clean_data = '0;
            default:
            begin
                // calibration only with full strength drive
                if (req_data[`XMR_ONE_HALF_DRV_BIT])
                    clean_data[`XMR_ONE_CAL_LSB+:3] = `XMR_CAL_EXIT;
                // adjust mode keeps the posted delay already programmed
                else if (req_data[`XMR_ONE_CAL_LSB+:3] == `XMR_CAL_ADJUST)
                    clean_data[`XMR_ONE_PCD_LSB+:3] =
                        shadow_one[`XMR_ONE_PCD_LSB+:3];
            end
        endcase
    end

    // a nonzero calibration code requires a trailing exit write
    assign needs_exit = (bank_ff == `XMR_BANK_ONE) &&
        (word_ff[`XMR_ONE_CAL_LSB+:3] != `XMR_CAL_EXIT);

    // exit word: held word with the calibration field forced to exit
    assign exit_word = {word_ff[12:`XMR_ONE_CAL_LSB+3], `XMR_CAL_EXIT,
                        word_ff[`XMR_ONE_CAL_LSB-1:0]};

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    // next state
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            xmr_pkg::XMR_IDLE:
                if (req_valid && banks_precharged)
                    nxt_state = xmr_pkg::XMR_ISSUE;
            xmr_pkg::XMR_ISSUE:
                nxt_state = xmr_pkg::XMR_RECOVER;
            xmr_pkg::XMR_RECOVER:
                if (!mrd_busy)
                    nxt_state = needs_exit ? xmr_pkg::XMR_EXIT
                                           : xmr_pkg::XMR_IDLE;
            xmr_pkg::XMR_EXIT:
                nxt_state = xmr_pkg::XMR_EXIT_RECOVER;
            xmr_pkg::XMR_EXIT_RECOVER:
                if (!mrd_busy)
                    nxt_state = xmr_pkg::XMR_IDLE;
            default:
                nxt_state = xmr_pkg::XMR_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_ff <= xmr_pkg::XMR_IDLE;
        else
            state_ff <= nxt_state;
    end

    // capture the request word and bank
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_ff <= '0;
            bank_ff <= `XMR_BANK_ONE;
        end
        else if (state_ff == xmr_pkg::XMR_IDLE && req_valid &&
                 banks_precharged)
        begin
            word_ff <= clean_data;
            bank_ff <= req_sel;
        end
        else if (state_ff == xmr_pkg::XMR_RECOVER && !mrd_busy)
            word_ff[`XMR_ONE_CAL_LSB+:3] <= `XMR_CAL_EXIT;
    end

    // ------------------------------------------------------------------
    // pins
    // ------------------------------------------------------------------
    // drive write command for one cycle, otherwise deselect with all control pins high
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_ff <= 1'b0;
            mem_ba <= 2'h0;
            mem_addr <= 13'h0000;
        end
        else
        begin
            cmd_ff <= (nxt_state == xmr_pkg::XMR_ISSUE) ||
                      (nxt_state == xmr_pkg::XMR_EXIT);
            if (nxt_state == xmr_pkg::XMR_ISSUE)
            begin
                mem_ba <= req_sel;
                mem_addr <= clean_data;
            end
            else if (nxt_state == xmr_pkg::XMR_EXIT)
            begin
                mem_ba <= bank_ff;
                mem_addr <= exit_word;
            end
        end
    end

    assign mem_cke = 1'b1;
    assign mem_cs_n = !cmd_ff;
    assign mem_ras_n = !cmd_ff;
    assign mem_cas_n = !cmd_ff;
    assign mem_we_n = !cmd_ff;

    // ------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------
    xmr_wait #(.WIDTH(8)) u_mrd (
        .clk(clk),
        .rst_n(rst_n),
        .load(cmd_ff),
        .count(8'(MRD_CYC)),
        .busy(mrd_busy)
    );

    xmr_wait #(.WIDTH(9)) u_lock (
        .clk(clk),
        .rst_n(rst_n),
        .load(dll_reset_done && dll_on_ff),
        .count(9'(LOCK_CYC)),
        .busy(lock_busy)
    );

    // track loop enable, shadow values and which registers were written
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dll_on_ff <= 1'b0;
            shadow_one <= 13'h0000;
            shadow_two <= 13'h0000;
            written <= 3'h0;
        end
        else if (cmd_ff)
        begin
            if (mem_ba == `XMR_BANK_ONE)
            begin
                dll_on_ff <= !mem_addr[`XMR_ONE_DLL_OFF_BIT];
                shadow_one <= mem_addr;
                written[0] <= 1'b1;
            end
            if (mem_ba == `XMR_BANK_TWO)
            begin
                shadow_two <= mem_addr;
                written[1] <= 1'b1;
            end
            if (mem_ba == `XMR_BANK_THREE)
                written[2] <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // status
    // ------------------------------------------------------------------
    assign req_ready = (state_ff == xmr_pkg::XMR_IDLE) && banks_precharged;
    assign wr_done = ((state_ff == xmr_pkg::XMR_RECOVER) && !mrd_busy &&
                      !needs_exit) ||
                     ((state_ff == xmr_pkg::XMR_EXIT_RECOVER) && !mrd_busy);
    assign cal_active = (state_ff != xmr_pkg::XMR_IDLE) && needs_exit;
    assign read_allowed = dll_on_ff && !lock_busy;
endmodule

// ### xmr_dev_model.sv
// behavioural ddr2 device model holding the extended registers
module xmr_dev_model (
    input wire logic clk,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    output logic [12:0] reg_one,
    output logic [12:0] reg_two,
    output logic [12:0] reg_three,
    output logic [2:0] last_cal,
    output int cmd_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cmd;
    logic [1:0] drive_lvl;
    logic dll_live;

    // write command decode, taken only with clock enable high
    assign cmd = cke && !cs_n && !ras_n && !cas_n && !we_n;
    initial cmd_cnt = 0;
    // registers stay unknown until first written
    // load the addressed register on the command edge
    always @(posedge clk)
    begin
        if (cmd && ba != 2'h0)
            cmd_cnt <= cmd_cnt + 1;
        if (cmd && ba == 2'h1)
            reg_one <= addr;
        if (cmd && ba == 2'h2)
            reg_two <= addr;
        if (cmd && ba == 2'h3)
            reg_three <= addr;
        if (cmd && ba == 2'h1 && addr[9:7] != 3'h0 && !addr[1])
            last_cal <= addr[9:7];
    end
    // output level in drive modes: 1 drives high, 2 drives low
    assign drive_lvl = reg_one[8:7];
    // loop runs only while clock enable is high, i.e. outside self refresh
    assign dll_live = cke && !reg_one[0];
endmodule

// ### xmr_ctrl_properties.sv
// concurrent checks on the extended register write controller
module xmr_ctrl_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic banks_precharged,
    input wire logic dll_reset_done,
    input wire logic req_ready,
    input wire logic wr_done,
    input wire logic read_allowed,
    input wire logic mem_cke,
    input wire logic mem_cs_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic [1:0] mem_ba,
    input wire logic [12:0] mem_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cmd;

    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // write command present on the pins
    assign cmd = !mem_cs_n && !mem_ras_n && !mem_cas_n && !mem_we_n;
    sequence cal_write;
        cmd && mem_ba == 2'h1 && mem_addr[9:7] != 3'h0;
    endsequence
    sequence exit_write;
        cmd && mem_ba == 2'h1 && mem_addr[9:7] == 3'h0;
    endsequence
    a_select_all_low: assert property (!mem_cs_n |-> cmd)
        else $error("partial command");
    a_bank_defined: assert property (cmd |-> mem_ba != 2'h0 && mem_cke)
        else $error("bad bank or clock enable");
    a_precharge_gate: assert property (req_ready |-> banks_precharged)
        else $error("ready with open banks");
    a_recovery_gap: assert property (cmd |=> !cmd [*2])
        else $error("write inside recovery");
    a_no_early_done: assert property (cmd |=> !wr_done [*2])
        else $error("done before recovery");
    a_two_masked: assert property (cmd && mem_ba == 2'h2 |->
        (mem_addr & 13'h1F78) == 13'h0000)
        else $error("reserved bit in register two");
    a_three_zero: assert property (cmd && mem_ba == 2'h3 |->
        mem_addr == 13'h0000)
        else $error("register three not zero");
    a_cal_exit: assert property (cal_write |-> ##[1:8] exit_write)
        else $error("calibration not exited");
    a_lock_blocks: assert property (dll_reset_done |=> !read_allowed [*3])
        else $error("read allowed during lock");
endmodule

bind xmr_ctrl xmr_ctrl_properties i_props (.clk(clk), .rst_n(rst_n),
    .banks_precharged(banks_precharged), .dll_reset_done(dll_reset_done),
    .req_ready(req_ready), .wr_done(wr_done), .read_allowed(read_allowed),
    .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
    .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba),
    .mem_addr(mem_addr));

// ### tb_xmr_ctrl.sv
// self-checking bench for the extended register write controller
module tb_xmr_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOCK = 20;
    logic clk, rst_n, req_valid, banks_precharged, dll_reset_done;
    logic req_ready, wr_done, read_allowed, mem_cke;
    logic cal_active, cal_seen;
    logic mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
    logic [1:0] mem_ba;
    logic [2:0] written, last_cal;
    logic [12:0] req_data, shadow_one, shadow_two, mem_addr;
    logic [12:0] reg_one, reg_two, reg_three;
    xmr_pkg::xmr_sel_type req_sel;
    int err_total = 0;
    int num_checks = 0;
    int cmd_cnt, c0;

    xmr_ctrl #(.MRD_CYC(2), .LOCK_CYC(LOCK)) i_dut (.clk(clk), .rst_n(rst_n),
        .req_valid(req_valid), .req_sel(req_sel), .req_data(req_data),
        .banks_precharged(banks_precharged), .dll_reset_done(dll_reset_done),
        .req_ready(req_ready), .wr_done(wr_done), .cal_active(cal_active),
        .read_allowed(read_allowed), .shadow_one(shadow_one),
        .shadow_two(shadow_two), .written(written), .mem_cke(mem_cke),
        .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
        .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr));
    xmr_dev_model i_dev (.clk(clk), .cke(mem_cke), .cs_n(mem_cs_n),
        .ras_n(mem_ras_n), .cas_n(mem_cas_n), .we_n(mem_we_n), .ba(mem_ba),
        .addr(mem_addr), .reg_one(reg_one), .reg_two(reg_two),
        .reg_three(reg_three), .last_cal(last_cal), .cmd_cnt(cmd_cnt));

    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [12:0] exp,
        input logic [12:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one write: hold the request until taken, then wait for done
    task automatic wr(input xmr_pkg::xmr_sel_type sel, input logic [12:0] d);
        int n;
        n = 0;
        req_sel <= sel;
        req_data <= d;
        req_valid <= 1'b1;
        do @(posedge clk); while (req_ready !== 1'b1 && ++n < 50);
        req_valid <= 1'b0;
        @(posedge clk);
        cal_seen = cal_active;
        do @(posedge clk); while (wr_done !== 1'b1 && ++n < 100);
        check("wr_done", 13'h0001, {12'h000, wr_done});
    endtask

    task automatic s_init();
        check("idle pins", 13'h001F, {8'h00, mem_cke, mem_cs_n, mem_ras_n,
            mem_cas_n, mem_we_n});
        wr(xmr_pkg::XMR_SEL_TWO, 13'h1FFF);
        check("reg_two", 13'h0087, reg_two);
        check("shadow_two", 13'h0087, shadow_two);
        wr(xmr_pkg::XMR_SEL_THREE, 13'h1FFF);
        check("reg_three", 13'h0000, reg_three);
        wr(xmr_pkg::XMR_SEL_ONE, 13'h045C);
        check("reg_one", 13'h045C, reg_one);
        check("shadow_one", 13'h045C, shadow_one);
        check("written", 13'h0007, {10'h000, written});
    endtask

    task automatic s_cal();
        logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
        foreach (codes[i])
        begin
            c0 = cmd_cnt;
            wr(xmr_pkg::XMR_SEL_ONE, {3'h0, codes[i], 7'h1C});
            check("cal code", {10'h000, codes[i]}, {10'h000, last_cal});
            check("cal active", 13'h0001, {12'h000, cal_seen});
            check("cal exit", 13'h001C, reg_one);
            check("cal cmds", 13'h0002, 13'(cmd_cnt - c0));
        end
        c0 = cmd_cnt;
        wr(xmr_pkg::XMR_SEL_ONE, 13'h0382);
        check("half reg", 13'h0002, reg_one);
        check("half cmds", 13'h0001, 13'(cmd_cnt - c0));
        check("half active", 13'h0000, {12'h000, cal_seen});
    endtask

    task automatic s_gate();
        c0 = cmd_cnt;
        banks_precharged <= 1'b0;
        req_sel <= xmr_pkg::XMR_SEL_TWO;
        req_data <= 13'h0001;
        req_valid <= 1'b1;
        repeat (6) @(posedge clk);
        check("gated ready", 13'h0000, {12'h000, req_ready});
        check("gated cmds", 13'h0000, 13'(cmd_cnt - c0));
        req_valid <= 1'b0;
        banks_precharged <= 1'b1;
        @(posedge clk);
        wr(xmr_pkg::XMR_SEL_TWO, 13'h0001);
        check("rewrite", 13'h0001, reg_two);
    endtask

    task automatic s_lock();
        wr(xmr_pkg::XMR_SEL_ONE, 13'h0000);
        dll_reset_done <= 1'b1;
        @(posedge clk);
        dll_reset_done <= 1'b0;
        repeat (LOCK - 3) @(posedge clk);
        check("lock wait", 13'h0000, {12'h000, read_allowed});
        repeat (6) @(posedge clk);
        check("locked", 13'h0001, {12'h000, read_allowed});
        wr(xmr_pkg::XMR_SEL_ONE, 13'h0001);
        check("loop off", 13'h0000, {12'h000, read_allowed});
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_sel = xmr_pkg::XMR_SEL_ONE;
        req_data = 13'h0000;
        banks_precharged = 1'b1;
        dll_reset_done = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        s_init();
        s_cal();
        s_gate();
        s_lock();
        print_verdict();
    end

    // watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule
